// file: pft_pkg.sv
// constants and types for program flow trace show-cycle logic
package pft_pkg;
    // register byte offsets
    localparam logic [7:0] PFT_OFF_CTRL = 8'h00;
    localparam logic [7:0] PFT_OFF_STAT = 8'h04;
    // field positions
    localparam int PFT_POL_LSB = 0;
    localparam int PFT_ST_PEND = 0;
    localparam int PFT_ST_SYNC = 1;
    localparam int PFT_ST_DBG = 2;
    localparam int PFT_ST_SER = 3;
    localparam int PFT_ST_NPOL = 4;
    // show policy encodings
    typedef enum logic [1:0] {
        POL_ALL = 2'h0,
        POL_COF = 2'h1,
        POL_IND = 2'h2,
        POL_SYNC = 2'h3
    } pft_pol_t;
    localparam pft_pol_t PFT_POL_RST = POL_SYNC;
    // queue status type codes
    localparam logic [2:0] QS_NONE = 3'h0;
    localparam logic [2:0] QS_SEQ = 3'h1;
    localparam logic [2:0] QS_NTK = 3'h2;
    localparam logic [2:0] QS_SYNC = 3'h3;
    localparam logic [2:0] QS_EXC = 3'h4;
    localparam logic [2:0] QS_IND = 3'h5;
    localparam logic [2:0] QS_DIR = 3'h6;
    localparam logic [2:0] QS_NTK2 = 3'h7;
    // history flush codes
    localparam logic [1:0] HF_MAX = 2'h2;
    localparam logic [1:0] HF_DEBUG = 2'h3;
    // cycle type codes
    localparam logic [3:0] CT_NORMAL = 4'h0;
    localparam logic [3:0] CT_IND_EXT = 4'h1;
    // sync sequencer states, gray from idle to drain to mark; mark back to idle flips both bits
    typedef enum logic [1:0] {
        SY_IDLE = 2'h0,
        SY_DRAIN = 2'h1,
        SY_MARK = 2'h3
    } pft_sync_t;
endpackage : pft_pkg

// file: pft_show_filter.sv
// decides whether an internal fetch is shown on the bus
`timescale 1ns/1ps
module pft_show_filter (
    input wire pft_pkg::pft_pol_t policy,
    input wire logic visSync,
    input wire logic isCof,
    input wire logic isIndirect,
    output logic show
);
    import pft_pkg::*;

    // policy table lookup
    always_comb begin
        unique case (policy)
            POL_ALL: show = 1'b1;
            POL_COF: show = isCof | isIndirect;
            POL_IND: show = isIndirect;
            POL_SYNC: show = visSync & isIndirect;
        endcase
    end
endmodule : pft_show_filter

// file: pft_trace.sv
// program flow trace show-cycle control with ahb-lite registers
`timescale 1ns/1ps
module pft_trace (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic devSyncStrobe,
    input wire logic devSyncValue,
    input wire logic pipeEmpty,
    input wire logic instValid,
    input wire logic [2:0] instKind,
    input wire logic instCtxSeq,
    input wire logic [2:0] cancelCount,
    input wire logic [1:0] histFlush,
    input wire logic debugMode,
    input wire logic fetchValid,
    input wire logic [31:0] fetchAddr,
    input wire logic fetchInternal,
    input wire logic [3:0] internalCycleType,
    input wire logic instFinished,
    input wire logic instException,
    input wire logic olderDone,
    output logic showValid,
    output logic [31:0] showAddr,
    output logic showAddrOnly,
    output logic wrPin,
    output logic [3:0] cycleTypeLines,
    output logic addressTypeBit1,
    output logic [2:0] queueStatusCode,
    output logic [1:0] historyFlushCode,
    output logic fetchSerialize,
    output logic pipeSyncReq,
    output logic archExecuted
);
    import pft_pkg::*;

    pft_pol_t activePol_q;
    pft_pol_t pendPol_q;
    pft_sync_t syncState_q;
    logic pend_q;
    logic visSync_q;
    logic markInd_q;
    logic cofNext_q;
    logic flushNext_q;
    logic apValid;
    logic ctrlWr;
    logic instStep;
    logic syncChange;
    logic setInd;
    logic showInt;
    logic dpWr_q;
    logic [7:0] dpAddr_q;
    logic [2:0] qsD;
    logic qsIsType;

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave

    // word transfers only; others complete with no effect
    assign apValid = hsel & htrans[1] & hready & (hsize == 3'h2);
    assign ctrlWr = dpWr_q & (dpAddr_q == PFT_OFF_CTRL);

    // address phase capture
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dpWr_q <= 1'b0;
            dpAddr_q <= 8'h00;
        end else begin
            dpWr_q <= apValid & hwrite;
            dpAddr_q <= haddr[7:0];
        end
    end

    // read data registered for the data phase
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0;
        end else if (apValid & ~hwrite) begin
            hrdata <= 32'h0;
            if (haddr[7:0] == PFT_OFF_CTRL) begin
                hrdata[PFT_POL_LSB +: 2] <= activePol_q;
            end else if (haddr[7:0] == PFT_OFF_STAT) begin
                hrdata[PFT_ST_PEND] <= pend_q;
                hrdata[PFT_ST_SYNC] <= visSync_q;
                hrdata[PFT_ST_DBG] <= debugMode;
                hrdata[PFT_ST_SER] <= fetchSerialize;
                hrdata[PFT_ST_NPOL +: 2] <= pendPol_q;
            end
        end
    end

    // zero wait, always okay
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // show policy with delayed take-over

    assign instStep = instValid & (instKind != QS_NONE);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            activePol_q <= PFT_POL_RST;
            pendPol_q <= PFT_POL_RST;
            pend_q <= 1'b0;
        end else if (ctrlWr) begin
            pendPol_q <= pft_pol_t'(hwdata[PFT_POL_LSB +: 2]);
            pend_q <= 1'b1;
        end else if (pend_q & instStep) begin
            activePol_q <= pendPol_q;
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fetchSerialize <= 1'b0;
        end else begin
            fetchSerialize <= (activePol_q == POL_ALL);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // visibility sync sequencer

    assign syncChange = (syncState_q == SY_IDLE) & devSyncStrobe
        & (devSyncValue != visSync_q);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            visSync_q <= 1'b0;
        end else if (syncChange) begin
            visSync_q <= devSyncValue;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncState_q <= SY_IDLE;
            pipeSyncReq <= 1'b0;
        end else begin
            unique case (syncState_q)
                SY_IDLE: begin
                    if (syncChange) begin
                        syncState_q <= SY_DRAIN;
                        pipeSyncReq <= 1'b1;
                    end
                end
                SY_DRAIN: begin
                    if (pipeEmpty) begin
                        syncState_q <= SY_MARK;
                        pipeSyncReq <= 1'b0;
                    end
                end
                SY_MARK: syncState_q <= SY_IDLE;
                default: begin
                    syncState_q <= SY_IDLE;
                    pipeSyncReq <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // change-of-flow marking of the next fetch

    assign setInd = (syncState_q == SY_MARK) | (instValid & (instCtxSeq
        | (instKind == QS_EXC) | (instKind == QS_IND)));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            markInd_q <= 1'b0;
        end else if (setInd) begin
            markInd_q <= 1'b1;
        end else if (fetchValid) begin
            markInd_q <= 1'b0;
        end
    end

    // direct taken target
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cofNext_q <= 1'b0;
        end else if (instValid & (instKind == QS_DIR)) begin
            cofNext_q <= 1'b1;
        end else if (fetchValid) begin
            cofNext_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fetch show cycle generation

    pft_show_filter u_filter (
        .policy(activePol_q),
        .visSync(visSync_q),
        .isCof(cofNext_q),
        .isIndirect(markInd_q),
        .show(showInt)
    );

    // external fetches always run full cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            showValid <= 1'b0;
            showAddr <= 32'h0;
            showAddrOnly <= 1'b0;
        end else begin
            showValid <= fetchValid & (~fetchInternal | showInt);
            showAddr <= fetchAddr;
            showAddrOnly <= fetchValid & fetchInternal;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrPin <= 1'b1;
            cycleTypeLines <= CT_NORMAL;
        end else if (fetchValid & fetchInternal) begin
            wrPin <= ~markInd_q;
            cycleTypeLines <= internalCycleType;
        end else if (fetchValid) begin
            wrPin <= 1'b1;
            cycleTypeLines <= markInd_q ? CT_IND_EXT : CT_NORMAL;
        end else begin
            wrPin <= 1'b1;
            cycleTypeLines <= CT_NORMAL;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            addressTypeBit1 <= 1'b0;
        end else begin
            addressTypeBit1 <= fetchValid;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fetch-time trace status

    always_comb begin
        qsD = QS_NONE;
        qsIsType = 1'b1;
        if (syncState_q == SY_MARK) begin
            qsD = QS_SYNC;
        end else if (flushNext_q & ~(instValid & (instKind == QS_NTK2))) begin
            qsD = cancelCount;
            qsIsType = 1'b0;
        end else if (instValid) begin
            qsD = instCtxSeq ? QS_IND : instKind;
        end
    end

    // report at fetch time each clock
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            queueStatusCode <= QS_NONE;
            flushNext_q <= 1'b0;
        end else if (debugMode) begin
            queueStatusCode <= QS_NONE;
            flushNext_q <= 1'b0;
        end else begin
            queueStatusCode <= qsD;
            flushNext_q <= qsIsType & qsD[2];
        end
    end

    // history flush count or debug mark
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            historyFlushCode <= 2'h0;
        end else if (debugMode) begin
            historyFlushCode <= HF_DEBUG;
        end else begin
            historyFlushCode <= (histFlush > HF_MAX) ? HF_MAX : histFlush;
        end
    end

    // clean finish of it and all older
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            archExecuted <= 1'b0;
        end else begin
            archExecuted <= instFinished & ~instException & olderDone;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_change;
        syncState_q == SY_IDLE && devSyncStrobe && devSyncValue != visSync_q;
    endsequence
    sequence s_drained;
        syncState_q == SY_DRAIN && pipeEmpty;
    endsequence

    a_all_fetch_shown: assert property (
        fetchValid && activePol_q == POL_ALL |=> showValid && fetchSerialize)
        else $error("show-all fetch not shown");
    a_cof_fetch_shown: assert property (
        fetchValid && activePol_q == POL_COF && (cofNext_q || markInd_q) |=> showValid)
        else $error("change-of-flow fetch not shown");
    a_ind_only_shown: assert property (
        fetchValid && fetchInternal && activePol_q == POL_IND && !markInd_q
        |=> !showValid)
        else $error("non-indirect fetch shown");
    a_none_shown: assert property (
        fetchValid && fetchInternal && activePol_q == POL_SYNC && !visSync_q
        |=> !showValid)
        else $error("fetch shown with shows off");
    a_policy_delay: assert property (
        pend_q && instStep && !ctrlWr |=> !pend_q && activePol_q == $past(pendPol_q))
        else $error("policy not taken over after one instruction");
    a_int_ind_wr: assert property (
        fetchValid && fetchInternal && markInd_q |=> !wrPin && showAddrOnly)
        else $error("internal indirect write/read not low");
    a_ext_ind_ct: assert property (
        fetchValid && !fetchInternal && markInd_q
        |=> cycleTypeLines == 4'h1 && wrPin && addressTypeBit1)
        else $error("external indirect cycle type wrong");
    a_ext_full_cycle: assert property (
        fetchValid && !fetchInternal |=> showValid && !showAddrOnly)
        else $error("external fetch not a full cycle");
    a_ctx_report: assert property (
        instValid && instCtxSeq && !debugMode && syncState_q == SY_IDLE
        && !flushNext_q |=> queueStatusCode == 3'h5 && markInd_q)
        else $error("context instruction not reported indirect");
    a_sync_follow: assert property (
        s_change |=> visSync_q == $past(devSyncValue) && pipeSyncReq)
        else $error("sync flag did not follow port");
    a_sync_mark: assert property (
        s_drained |=> syncState_q == SY_MARK && !pipeSyncReq ##1 markInd_q)
        else $error("sync change not marked");
    a_debug_codes: assert property (
        debugMode |=> queueStatusCode == 3'h0 && historyFlushCode == 2'h3)
        else $error("debug status codes wrong");
    a_arch_exec: assert property (
        instFinished && (instException || !olderDone) |=> !archExecuted)
        else $error("executed flag despite exception");
endmodule : pft_trace

// file: pft_bus_tool.sv
// behavioural trace capture tool: counts show cycles, sends sync over debug port
`timescale 1ns/1ps
module pft_bus_tool (
    input wire logic mclk,
    input wire logic showValid,
    output logic devSyncStrobe,
    output logic devSyncValue
);
    int showCount = 0;

    // idle debug port
    initial begin
        devSyncStrobe = 1'b0;
        devSyncValue = 1'b1;
    end

    // capture each show cycle seen on the bus
    always @(posedge mclk) begin
        if (showValid === 1'b1) begin
            showCount++;
        end
    end

    task automatic sendSync(input logic v);
        @(posedge mclk);
        devSyncStrobe <= 1'b1;
        devSyncValue <= v;
        @(posedge mclk);
        devSyncStrobe <= 1'b0;
        devSyncValue <= ~v; // value not held after the transmission
    endtask : sendSync
endmodule : pft_bus_tool

// file: test_pft_trace.sv
// self-checking bench for the program flow trace show-cycle block
`timescale 1ns/1ps
module test_pft_trace;
    import pft_pkg::*;
    logic mclk = 1'b0;
    logic resetN, hsel, hwrite, pipeEmpty, instValid, instCtxSeq, debugMode, fetchValid;
    logic fetchInternal, instFinished, instException, olderDone;
    logic [31:0] haddr, hwdata, fetchAddr, hrdata, showAddr, rd;
    logic [1:0] htrans, histFlush, historyFlushCode;
    logic [2:0] hsize, instKind, cancelCount, queueStatusCode;
    logic [3:0] internalCycleType, cycleTypeLines;
    logic hreadyout, hresp, showValid, showAddrOnly, wrPin, addressTypeBit1;
    logic fetchSerialize, pipeSyncReq, archExecuted, devSyncStrobe, devSyncValue;
    int errCount = 0;
    int checksDone = 0;
    int cycles = 0;
    int expShows = 0;

    pft_trace u_dut (
        .mclk(mclk), .reset_n(resetN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .devSyncStrobe(devSyncStrobe), .devSyncValue(devSyncValue), .pipeEmpty(pipeEmpty),
        .instValid(instValid), .instKind(instKind), .instCtxSeq(instCtxSeq),
        .cancelCount(cancelCount), .histFlush(histFlush), .debugMode(debugMode),
        .fetchValid(fetchValid), .fetchAddr(fetchAddr), .fetchInternal(fetchInternal),
        .internalCycleType(internalCycleType), .instFinished(instFinished),
        .instException(instException), .olderDone(olderDone), .showValid(showValid),
        .showAddr(showAddr), .showAddrOnly(showAddrOnly), .wrPin(wrPin),
        .cycleTypeLines(cycleTypeLines), .addressTypeBit1(addressTypeBit1),
        .queueStatusCode(queueStatusCode), .historyFlushCode(historyFlushCode),
        .fetchSerialize(fetchSerialize), .pipeSyncReq(pipeSyncReq),
        .archExecuted(archExecuted)
    );

    pft_bus_tool u_tool (
        .mclk(mclk), .showValid(showValid), .devSyncStrobe(devSyncStrobe),
        .devSyncValue(devSyncValue)
    );

    // core clock, 40 ns period
    always #20 mclk = ~mclk;

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errCount++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // wait for hready at a rising edge; only the hang guard ends a wait that never sees it
    task automatic busWait();
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
    endtask : busWait

    // single word transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        busWait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        busWait();
        rd = hrdata;
    endtask : ahb

    task automatic fetch(input logic [31:0] a, input logic i, input logic [3:0] t, input logic e);
        @(posedge mclk);
        fetchValid <= 1'b1;
        fetchAddr <= a;
        fetchInternal <= i;
        internalCycleType <= t;
        @(posedge mclk);
        fetchValid <= 1'b0;
        #1;
        expShows += e;
        chk(showValid, e);
    endtask : fetch

    task automatic inst(input logic [2:0] k, input logic x, input logic [2:0] c,
                        input logic [2:0] q);
        @(posedge mclk);
        instValid <= 1'b1;
        instKind <= k;
        instCtxSeq <= x;
        @(posedge mclk);
        instValid <= 1'b0;
        instCtxSeq <= 1'b0;
        cancelCount <= c;
        #1;
        chk(queueStatusCode, q);
        @(posedge mclk);
        cancelCount <= 3'h0;
        #1;
        chk(queueStatusCode, q[2] ? c : QS_NONE);
    endtask : inst

    ////////////////////////////////////////////////////////////////////////////
    task automatic testIdle();
        ahb(1'b0, PFT_OFF_CTRL, 32'h0);
        chk(rd[1:0], 2'h3);
        fetch(32'h100, 1'b1, 4'h4, 1'b0);
        fetch(32'h200, 1'b0, 4'h0, 1'b1);
        chk(showAddr, 32'h200);
        chk(showAddrOnly, 1'b0);
        chk(cycleTypeLines, CT_NORMAL);
    endtask : testIdle

    task automatic testSync();
        int n;
        u_tool.sendSync(1'b1);
        @(posedge mclk);
        #1;
        chk(pipeSyncReq, 1'b1);
        @(posedge mclk);
        pipeEmpty <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (queueStatusCode !== QS_SYNC && n < 6);
        chk(queueStatusCode, QS_SYNC);
        chk(pipeSyncReq, 1'b0);
        @(posedge mclk);
        pipeEmpty <= 1'b0;
        fetch(32'h300, 1'b1, 4'h5, 1'b1);
        chk(wrPin, 1'b0);
        fetch(32'h304, 1'b1, 4'h5, 1'b0);
        ahb(1'b1, PFT_OFF_STAT, 32'h0);
        ahb(1'b0, PFT_OFF_STAT, 32'h0);
        chk(rd[1], 1'b1);
    endtask : testSync

    task automatic testPolicy();
        ahb(1'b1, PFT_OFF_CTRL, 32'h0);
        ahb(1'b1, 8'h08, 32'hffffffff);
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        chk({hreadyout, hresp}, 2'h2);
        ahb(1'b0, PFT_OFF_CTRL, 32'h0);
        chk(rd[1:0], 2'h3);
        ahb(1'b0, PFT_OFF_STAT, 32'h0);
        chk(rd & 32'h3f, 32'h3);
        fetch(32'h3f0, 1'b1, 4'h4, 1'b0);
        inst(3'h1, 1'b0, 3'h0, QS_SEQ);
        ahb(1'b0, PFT_OFF_CTRL, 32'h0);
        chk(rd[1:0], 2'h0);
        chk(fetchSerialize, 1'b1);
        fetch(32'h400, 1'b1, 4'h4, 1'b1);
        chk(showAddrOnly, 1'b1);
    endtask : testPolicy

    task automatic testCof();
        ahb(1'b1, PFT_OFF_CTRL, 32'h1);
        inst(3'h6, 1'b0, 3'h2, QS_DIR);
        fetch(32'h500, 1'b1, 4'h4, 1'b1);
        chk(wrPin, 1'b1);
        chk(fetchSerialize, 1'b0);
        inst(3'h1, 1'b0, 3'h0, QS_SEQ);
        fetch(32'h504, 1'b1, 4'h4, 1'b0);
    endtask : testCof

    task automatic testIndirect();
        ahb(1'b1, PFT_OFF_CTRL, 32'h2);
        inst(3'h1, 1'b0, 3'h0, QS_SEQ);
        inst(3'h5, 1'b0, 3'h3, QS_IND);
        fetch(32'h600, 1'b1, 4'h6, 1'b1);
        chk(wrPin, 1'b0);
        chk(cycleTypeLines, 4'h6);
        chk(addressTypeBit1, 1'b1);
        inst(3'h4, 1'b0, 3'h5, QS_EXC);
        fetch(32'h700, 1'b0, 4'h0, 1'b1);
        chk(cycleTypeLines, CT_IND_EXT);
        chk(wrPin, 1'b1);
        chk(addressTypeBit1, 1'b1);
        inst(3'h1, 1'b1, 3'h0, QS_IND);
        fetch(32'h800, 1'b1, 4'h4, 1'b1);
        inst(3'h6, 1'b0, 3'h0, QS_DIR);
        fetch(32'h900, 1'b1, 4'h4, 1'b0);
        for (int k = 2; k < 8; k += 5) begin
            inst(k[2:0], 1'b0, 3'h1, k[2:0]);
        end
        // not-taken report in the flush slot
        @(posedge mclk);
        instValid <= 1'b1;
        instKind <= QS_EXC;
        @(posedge mclk);
        instKind <= QS_NTK2;
        cancelCount <= 3'h4;
        @(posedge mclk);
        instValid <= 1'b0;
        #1;
        chk(queueStatusCode, QS_NTK2);
        @(posedge mclk);
        cancelCount <= 3'h0;
        #1;
        chk(queueStatusCode, 3'h4);
    endtask : testIndirect

    task automatic testDebug();
        @(posedge mclk);
        debugMode <= 1'b1;
        histFlush <= 2'h2;
        @(posedge mclk);
        #1;
        chk(queueStatusCode, QS_NONE);
        chk(historyFlushCode, HF_DEBUG);
        @(posedge mclk);
        debugMode <= 1'b0;
        @(posedge mclk);
        histFlush <= 2'h3;
        #1;
        chk(historyFlushCode, 2'h2);
        @(posedge mclk);
        histFlush <= 2'h0;
        #1;
        chk(historyFlushCode, HF_MAX);
    endtask : testDebug

    task automatic testExec();
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            {instFinished, instException, olderDone} <= i[2:0];
            @(posedge mclk);
            #1;
            chk(archExecuted, i[2] & ~i[1] & i[0]);
        end
        chk(addressTypeBit1, 1'b0);
    endtask : testExec

    ////////////////////////////////////////////////////////////////////////////
    // reset, then each scenario in turn
    initial begin
        resetN = 1'b0;
        {hsel, hwrite, pipeEmpty, instValid, instCtxSeq, debugMode, fetchValid, fetchInternal,
            instFinished, instException, olderDone, haddr, hwdata, fetchAddr, htrans,
            histFlush, hsize, instKind, cancelCount, internalCycleType} = '0;
        repeat (10) @(posedge mclk);
        resetN <= 1'b1;
        testIdle();
        testSync();
        testPolicy();
        testCof();
        testIndirect();
        testDebug();
        testExec();
        repeat (2) @(posedge mclk);
        chk(u_tool.showCount, expShows);
        conclude();
    end
endmodule : test_pft_trace
